// ==== prhm_buf.v ====
// Two-entry octet buffer between the assembler and the output port.
// Assumes one clock, synchronous active-high reset; flush empties it.
`include "prhm_map.vh"

module prhm_buf
(
	input  wire       mclk,
	input  wire       rst,
	input  wire       flush,
	input  wire       wr_valid,
	input  wire [7:0] wr_data,
	output wire       wr_ready,
	output reg        rd_valid_q,
	output reg  [7:0] rd_data_q,
	input  wire       rd_ready
);

	reg        tail_v_q;
	reg  [7:0] tail_q;
	wire       push;
	wire       pop;

	// Head register is the output, so the port comes straight from a flop
	assign wr_ready = ~(rd_valid_q & tail_v_q);
	assign push     = wr_valid & wr_ready;
	assign pop      = rd_valid_q & rd_ready;

	always @(posedge mclk)
	begin
		if (rst || flush)
		begin
			rd_valid_q <= 1'b0;
			tail_v_q   <= 1'b0;
			rd_data_q  <= `PRHM_DATA_RST;
			tail_q     <= `PRHM_DATA_RST;
		end
		else if (pop)
		begin
			if (tail_v_q)
			begin
				rd_data_q <= tail_q;
				tail_v_q  <= push;
				if (push)
					tail_q <= wr_data;
			end
			else
			begin
				rd_valid_q <= push;
				if (push)
					rd_data_q <= wr_data;
			end
		end
		else if (push)
		begin
			if (!rd_valid_q)
			begin
				rd_valid_q <= 1'b1;
				rd_data_q  <= wr_data;
			end
			else
			begin
				tail_v_q <= 1'b1;
				tail_q   <= wr_data;
			end
		end
	end

endmodule // prhm_buf

// ==== prhm_checker.sv ====
// Port assertions for the random generator health monitor.
// Bound to every prhm_top; one clock, synchronous active-high reset.
module prhm_checker
(
	input logic		mclk,
	input logic		rst,
	input logic		rng_en,
	input logic		selftest_req,
	input logic		out_ready,
	input logic [7:0]	out_data,
	input logic		out_valid,
	input logic		tf_fail_q,
	input logic		ol_fail_q,
	input logic		rng_healthy_q,
	input logic		st_busy_q,
	input logic		st_done_q,
	input logic		st_pass_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_stall;
		out_valid && !out_ready;
	endsequence
	sequence s_st_take;
		selftest_req && rng_en && rng_healthy_q && !st_busy_q;
	endsequence
	a_valid_health:
		assert property (out_valid |-> rng_healthy_q && !tf_fail_q && !ol_fail_q)
		else $error("valid while unhealthy");
	a_stall_hold:
		assert property (s_stall ##1 rng_healthy_q |-> out_valid && $stable(out_data))
		else $error("stalled octet lost");
	a_off_idle:
		assert property (!rng_en |=> !rng_healthy_q && !out_valid && !st_busy_q)
		else $error("active while disabled");
	a_fail_health:
		assert property ($rose(tf_fail_q) || $rose(ol_fail_q) |-> !rng_healthy_q && !out_valid)
		else $error("output after failure");
	a_tf_sticky:
		assert property (tf_fail_q && rng_en && $past(rng_en) |=> tf_fail_q)
		else $error("stuck flag dropped");
	a_ol_sticky:
		assert property (ol_fail_q && rng_en && $past(rng_en) |=> ol_fail_q)
		else $error("defect flag dropped");
	a_st_start:
		assert property (s_st_take |=> st_busy_q && !st_done_q && !st_pass_q)
		else $error("self-test not started");
	a_pass_done:
		assert property (st_pass_q |-> st_done_q && !st_busy_q)
		else $error("pass without done");
	a_rst_quiet:
		assert property (disable iff (1'b0) rst |=> !out_valid && !rng_healthy_q && !st_done_q)
		else $error("outputs after reset");
endmodule // prhm_checker

bind prhm_top prhm_checker prhm_checker_inst (.mclk, .rst, .rng_en, .selftest_req, .out_ready, .out_data,
	.out_valid, .tf_fail_q, .ol_fail_q, .rng_healthy_q, .st_busy_q, .st_done_q, .st_pass_q);

// ==== prhm_map.vh ====
// Constants for the physical random generator health monitor.
// Assumes a single 50 MHz clock; included by its bare name.
`ifndef PRHM_MAP_VH
`define PRHM_MAP_VH

// Clock period and raw bit sampling period, in ns
`define PRHM_CLK_NS      8'h14
`define PRHM_SAMPLE_NS   8'h64
// Least time, so round up
`define PRHM_SAMPLE_CYC  ((`PRHM_SAMPLE_NS + `PRHM_CLK_NS - 8'h01) / `PRHM_CLK_NS)

// Identical raw bits in a row that mean a dead source
`define PRHM_TF_RUN      6'h30
// Online test window, last bit index (512 bits)
`define PRHM_WIN_LAST    9'h1FF
// Ones per window; bias of 0.032 stays inside, so entropy > 0.997
`define PRHM_ONES_LO     10'h0D8
`define PRHM_ONES_HI     10'h128
// Bit changes per window
`define PRHM_TRANS_LO    10'h0C8
`define PRHM_TRANS_HI    10'h138
// Untested windows between tests in interval mode
`define PRHM_SKIP_WIN    4'h8
// Reset value of data registers
`define PRHM_DATA_RST    8'h00

`endif

// ==== prhm_top.v ====
// Physical random generator with stuck-source and statistical checks.
// Assumes raw_bit is an asynchronous entropy source and software drives
// the control inputs from the mclk domain.
`include "prhm_map.vh"

module prhm_top
(
	input  wire       mclk,
	input  wire       rst,
	input  wire       rng_en,
	input  wire       cont_mode,
	input  wire       selftest_req,
	input  wire       raw_bit,
	input  wire       out_ready,
	output wire [7:0] out_data,
	output wire       out_valid,
	output reg        tf_fail_q,
	output reg        ol_fail_q,
	output reg        rng_healthy_q,
	output reg        st_busy_q,
	output reg        st_done_q,
	output reg        st_pass_q
);

	localparam [3:0] ST_IDLE    = 4'h1;
	localparam [3:0] ST_STARTUP = 4'h2;
	localparam [3:0] ST_RUN     = 4'h4;
	localparam [3:0] ST_FAIL    = 4'h8;
	// Sample period fits three bits; cut on purpose
	localparam integer SMP_CYC  = `PRHM_SAMPLE_CYC;
	localparam [2:0] SMP_LAST   = SMP_CYC[2:0] - 3'h1;

	reg  [3:0] state_q;
	reg  [3:0] state_d;
	reg        sync1_q;
	reg        sync2_q;
	reg        sync3_q;
	reg        filt_q;
	reg  [2:0] smp_cnt_q;
	reg        last_q;
	reg  [5:0] run_q;
	reg  [8:0] win_q;
	reg  [9:0] ones_q;
	reg  [9:0] trans_q;
	reg  [3:0] skip_q;
	reg  [6:0] sh_q;
	reg  [2:0] bit_cnt_q;
	reg        asm_v_q;
	reg  [7:0] asm_q;

	wire       tick;
	wire       bit_now;
	wire       active;
	wire       tf_hit;
	wire       win_end;
	wire       testing;
	wire [9:0] ones_nx;
	wire [9:0] trans_nx;
	wire       win_pass;
	wire       st_start;
	wire       buf_ready;
	wire       accept;
	wire       flush;

	// Raw source is asynchronous; only agreeing later stages are trusted
	// Filter swallows a value that stands for a single clock
	always @(posedge mclk)
	begin
		if (rst)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			filt_q  <= 1'b0;
		end
		else
		begin
			sync1_q <= raw_bit;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			if (sync2_q == sync3_q)
				filt_q <= sync3_q;
		end
	end

	// Sampling rate bounds how fast the source must toggle
	always @(posedge mclk)
	begin
		if (rst || !rng_en || smp_cnt_q == SMP_LAST)
			smp_cnt_q <= 3'h0;
		else
			smp_cnt_q <= smp_cnt_q + 3'h1;
	end

	assign active  = rng_en & ~state_q[0] & ~state_q[3];
	assign tick    = active & (smp_cnt_q == SMP_LAST);
	assign bit_now = filt_q;

	// stuck run detect
	// Limitation: octets from the first equal bits may leave before the run limit
	assign tf_hit = tick & (bit_now == last_q) & (run_q == `PRHM_TF_RUN - 6'h01);

	assign ones_nx  = ones_q + {9'h000, bit_now};
	assign trans_nx = trans_q + {9'h000, bit_now ^ last_q};
	assign win_end  = tick & (win_q == `PRHM_WIN_LAST);
	assign win_pass = (ones_nx >= `PRHM_ONES_LO) && (ones_nx <= `PRHM_ONES_HI) &&
	                  (trans_nx >= `PRHM_TRANS_LO) && (trans_nx <= `PRHM_TRANS_HI);
	// interval or continuous
	// Untested windows still gather counts; only their verdict is dropped
	assign testing  = cont_mode | (skip_q == 4'h0) | state_q[1] | st_busy_q;

	// Self-test restarts the window so its verdict covers fresh bits only
	assign st_start = selftest_req & active & ~st_busy_q;

	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (rng_en)
					state_d = ST_STARTUP;
			end
			ST_STARTUP:
			begin
				if (tf_hit || (win_end && !win_pass))
					state_d = ST_FAIL;
				else if (win_end)
					state_d = ST_RUN;
			end
			ST_RUN:
			begin
				if (tf_hit || (win_end && testing && !win_pass))
					state_d = ST_FAIL;
			end
			ST_FAIL:
			begin
				state_d = ST_FAIL;
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
		if (!rng_en)
			state_d = ST_IDLE;
	end

	always @(posedge mclk)
	begin
		if (rst)
		begin
			state_q       <= ST_IDLE;
			tf_fail_q     <= 1'b0;
			ol_fail_q     <= 1'b0;
			rng_healthy_q <= 1'b0;
		end
		else
		begin
			state_q       <= state_d;
			rng_healthy_q <= (state_d == ST_RUN);
			// Flags stay until software restarts the generator
			// Clear needs idle and set needs active, so they never meet
			if (state_q == ST_IDLE && rng_en)
			begin
				tf_fail_q <= 1'b0;
				ol_fail_q <= 1'b0;
			end
			else if (active && state_d == ST_FAIL)
			begin
				tf_fail_q <= tf_fail_q | tf_hit;
				ol_fail_q <= ol_fail_q | ~tf_hit;
			end
		end
	end

	always @(posedge mclk)
	begin
		if (rst || !active)
		begin
			last_q  <= 1'b0;
			run_q   <= 6'h00;
			win_q   <= 9'h000;
			ones_q  <= 10'h000;
			trans_q <= 10'h000;
			skip_q  <= 4'h0;
		end
		else
		begin
			if (tick)
			begin
				last_q <= bit_now;
				if (bit_now != last_q)
					run_q <= 6'h01;
				else if (run_q != `PRHM_TF_RUN)
					run_q <= run_q + 6'h01;
			end
			if (st_start || win_end)
			begin
				win_q   <= 9'h000;
				ones_q  <= 10'h000;
				trans_q <= 10'h000;
			end
			else if (tick)
			begin
				win_q   <= win_q + 9'h001;
				ones_q  <= ones_nx;
				trans_q <= trans_nx;
			end
			if (win_end && testing)
				skip_q <= `PRHM_SKIP_WIN;
			else if (win_end)
				skip_q <= skip_q - 4'h1;
		end
	end

	always @(posedge mclk)
	begin
		if (rst)
		begin
			st_busy_q <= 1'b0;
			st_done_q <= 1'b0;
			st_pass_q <= 1'b0;
		end
		else if (st_start)
		begin
			st_busy_q <= 1'b1;
			st_done_q <= 1'b0;
			st_pass_q <= 1'b0;
		end
		else if (st_busy_q && (!active || tf_hit || win_end))
		begin
			st_busy_q <= 1'b0;
			st_done_q <= 1'b1;
			st_pass_q <= active & ~tf_hit & win_pass;
		end
	end

	// Buffer refuses while both entries hold; slow bit rate hides the gap
	assign accept = asm_v_q & buf_ready;
	// drop queued octets
	// Next state, so queued octets die on the failing edge itself
	assign flush  = (state_d != ST_RUN);

	// Source cannot stall, so bits arriving while full are skipped
	always @(posedge mclk)
	begin
		if (rst || flush)
		begin
			sh_q      <= 7'h00;
			bit_cnt_q <= 3'h0;
			asm_v_q   <= 1'b0;
			asm_q     <= `PRHM_DATA_RST;
		end
		else if (tick && (!asm_v_q || accept))
		begin
			sh_q      <= {sh_q[5:0], bit_now};
			bit_cnt_q <= bit_cnt_q + 3'h1;
			if (bit_cnt_q == 3'h7)
			begin
				asm_v_q <= 1'b1;
				asm_q   <= {sh_q, bit_now};
			end
			else
				asm_v_q <= 1'b0;
		end
		else if (accept)
			asm_v_q <= 1'b0;
	end

	prhm_buf u_buf
	(
		.mclk       (mclk),
		.rst        (rst),
		.flush      (flush),
		.wr_valid   (asm_v_q),
		.wr_data    (asm_q),
		.wr_ready   (buf_ready),
		.rd_valid_q (out_valid),
		.rd_data_q  (out_data),
		.rd_ready   (out_ready)
	);

endmodule // prhm_top

// ==== tb.sv ====
// Self-checking bench for the random generator health monitor.
// Raw bits come from a pattern source, one per 100 ns sample period.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic		mclk, rst, rng_en, cont_mode, selftest_req, out_ready;
	logic		raw_bit = 1'h0;
	logic		out_valid, tf_fail_q, ol_fail_q, rng_healthy_q, st_busy_q, st_done_q, st_pass_q;
	logic [7:0]	out_data;
	logic [7:0]	pat_q = 8'hD0;
	logic [15:0]	lfsr_q = 16'hACE1;
	logic [1:0]	mode;
	logic [5:0]	rows [5];
	int		fails, n_checks, k;
	int		ph = 0;

	prhm_top prhm_top_inst (.mclk, .rst, .rng_en, .cont_mode, .selftest_req, .raw_bit, .out_ready,
		.out_data, .out_valid, .tf_fail_q, .ol_fail_q, .rng_healthy_q, .st_busy_q, .st_done_q, .st_pass_q);

	initial
	begin
		mclk = 0;
		forever #10 mclk = ~mclk;
	end

	// Modes: fair sequence, stuck 0, stuck 1, fixed 8-bit pattern
	always @(posedge mclk)
	begin
		ph <= (ph == 4) ? 0 : ph + 1;
		if (ph == 0)
		begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
			pat_q <= {pat_q[6:0], pat_q[7]};
			raw_bit <= (mode == 0) ? lfsr_q[15] : (mode == 3) ? pat_q[7] : mode[1];
		end
	end

	task chk(string n, logic e, logic g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s exp %b got %b", n, e, g);
		end
	endtask

	task final_report;
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task wt(int n);
		repeat (n) @(posedge mclk);
	endtask

	// Restart from idle and let the start-up window finish
	task start(logic c, logic [1:0] m);
		@(posedge mclk);
		rng_en <= 0;
		cont_mode <= c;
		mode <= m;
		wt(2);
		rng_en <= 1;
		wt(2700);
	endtask

	task flags(logic h, logic t, logic o);
		@(negedge mclk);
		chk("healthy", h, rng_healthy_q);
		chk("tf_fail", t, tf_fail_q);
		chk("ol_fail", o, ol_fail_q);
	endtask

	// MSB-first octets of the pattern are rotations of D0
	function automatic logic rot_ok(logic [7:0] v);
		rot_ok = 0;
		for (int i = 0; i < 8; i++)
			if (v === ((8'hD0 << i) | (8'hD0 >> (8 - i))))
				rot_ok = 1;
	endfunction

	task rx(int n);
		repeat (n)
		begin
			@(negedge mclk);
			if (out_valid && out_ready)
				chk("octet", 1, rot_ok(out_data));
		end
	endtask

	task selftest(logic p);
		@(posedge mclk);
		selftest_req <= 1;
		@(posedge mclk);
		selftest_req <= 0;
		@(negedge mclk);
		chk("st_busy", 1, st_busy_q);
		k = 0;
		do
		begin
			@(negedge mclk);
			k++;
		end
		while (st_done_q !== 1 && k < 3000);
		chk("st_done", 1, st_done_q);
		chk("st_pass", p, st_pass_q);
		chk("st_idle", 0, st_busy_q);
	endtask

	initial
	begin
		rst = 1;
		{rng_en, cont_mode, selftest_req, out_ready, mode} = 0;
		// Row: cont_mode, source mode, healthy, tf_fail, ol_fail
		rows = '{6'h04, 6'h24, 6'h0A, 6'h32, 6'h19};
		wt(5);
		rst <= 0;
		foreach (rows[i])
		begin
			start(rows[i][5], rows[i][4:3]);
			flags(rows[i][2], rows[i][1], rows[i][0]);
		end
		// Weak pattern survives the skipped windows of interval mode
		start(0, 0);
		@(posedge mclk);
		mode <= 3;
		out_ready <= 1;
		wt(200);
		rx(400);
		@(posedge mclk);
		out_ready <= 0;
		wt(300);
		@(negedge mclk);
		chk("stall_valid", 1, out_valid);
		@(posedge mclk);
		out_ready <= 1;
		rx(400);
		flags(1, 0, 0);
		start(1, 0);
		@(posedge mclk);
		mode <= 3;
		wt(5400);
		flags(0, 0, 1);
		start(0, 0);
		@(posedge mclk);
		mode <= 1;
		wt(300);
		flags(0, 1, 0);
		chk("valid_off", 0, out_valid);
		start(1, 0);
		selftest(1);
		@(posedge mclk);
		mode <= 1;
		selftest(0);
		// Mid-run reset out of a latched failure, then a clean restart
		@(posedge mclk);
		rst <= 1;
		mode <= 0;
		wt(3);
		@(negedge mclk);
		chk("rst_tf", 0, tf_fail_q);
		chk("rst_done", 0, st_done_q);
		chk("rst_valid", 0, out_valid);
		@(posedge mclk);
		rst <= 0;
		wt(2700);
		flags(1, 0, 0);
		final_report;
	end

	// Run needs about 0.75 ms
	initial
	begin
		#1ms;
		fails++;
		final_report;
	end
endmodule // tb
